// ---- logic/pcs_core_reversal_double_rate.sv ----
// PCS-to-fabric datapath: reversal options and double rate transfer.
// Assumes fabric words arrive in the aclk domain; the doubled and
// full-rate phases are enable strobes derived from aclk.
`timescale 1ns/1ps
`default_nettype none

module pcs_core_reversal_double_rate (
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  input  wire logic                                   clk_en,
  input  wire logic [31:0]                            s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [31:0]                            s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  input  wire logic [31:0]                            s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [31:0]                                 s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready,
  input  wire logic                                   tx_fabric_doubled_clk_in,
  input  wire logic [pcs_core_pkg::CHANNELS*pcs_core_pkg::HALF_W-1:0] tx_half_data,
  input  wire logic [pcs_core_pkg::CHANNELS-1:0]      tx_half_mark,
  output logic [pcs_core_pkg::CHANNELS*pcs_core_pkg::FULL_W-1:0] tx_pcs_word,
  output logic                                        tx_pcs_word_valid,
  input  wire logic [pcs_core_pkg::CHANNELS*pcs_core_pkg::FULL_W-1:0] rx_pcs_word,
  input  wire logic                                   rx_pcs_word_valid,
  input  wire logic [pcs_core_pkg::CHANNELS-1:0]      rx_bit_flip_en,
  input  wire logic [pcs_core_pkg::CHANNELS-1:0]      rx_byte_swap_en,
  output logic [pcs_core_pkg::CHANNELS*pcs_core_pkg::HALF_W-1:0] rx_half_data,
  output logic [pcs_core_pkg::CHANNELS-1:0]           rx_half_mark,
  output logic                                        rx_half_valid,
  output logic                                        tx_full_rate_clk_out,
  output logic                                        rx_full_rate_clk_out
);

  localparam int unsigned CH = pcs_core_pkg::CHANNELS;
  localparam int unsigned FW = pcs_core_pkg::FULL_W;
  localparam int unsigned HW = pcs_core_pkg::HALF_W;
  localparam int unsigned SW = pcs_core_pkg::SYM_W;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Both directions reverse the whole word, so one mirror and one swap serve both.
  function automatic logic [FW-1:0] mirror_full(input logic [FW-1:0] d);
    mirror_full = {<<{d}};
  endfunction

  function automatic logic [FW-1:0] swap_full(input logic [FW-1:0] d);
    swap_full = {<<SW{d}};
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [CH-1:0] bitf_s1_r;
  logic [CH-1:0] bitf_r;
  logic [CH-1:0] bytef_s1_r;
  logic [CH-1:0] bytef_r;
  logic          dclk_s1_r;
  logic          dclk_s2_r;
  logic          dclk_s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitf_s1_r  <= '0;
      bitf_r     <= '0;
      bytef_s1_r <= '0;
      bytef_r    <= '0;
      dclk_s1_r  <= 1'b0;
      dclk_s2_r  <= 1'b0;
      dclk_s3_r  <= 1'b0;
    end else if (clk_en) begin
      bitf_s1_r  <= rx_bit_flip_en;
      bitf_r     <= bitf_s1_r;
      bytef_s1_r <= rx_byte_swap_en;
      bytef_r    <= bytef_s1_r;
      dclk_s1_r  <= tx_fabric_doubled_clk_in;
      dclk_s2_r  <= dclk_s1_r;
      dclk_s3_r  <= dclk_s2_r;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] cfg_r;
  logic        rejected_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        low_seen_r;
  logic        up_seen_r;

  logic        drt_req;
  logic        drt_ok;
  logic        drt_on;
  logic        do_write;
  logic [31:0] ctrl_nxt;

  assign drt_req  = ctrl_r[pcs_core_pkg::CTRL_DRT_BIT];
  assign drt_ok   = (cfg_r[pcs_core_pkg::CFG_PCSW_LSB +: 8] > 8'(pcs_core_pkg::MIN_DRT_W))
                 && (cfg_r[pcs_core_pkg::CFG_COREW_LSB +: 8] > 8'(pcs_core_pkg::MIN_DRT_W));
  assign drt_on   = drt_req && drt_ok && !ctrl_r[pcs_core_pkg::CTRL_SIMP_BIT];
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_comb begin
    ctrl_nxt = ctrl_r;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) begin
        ctrl_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
      end
    end
  end

  // Address and data are latched independently so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pcs_core_pkg::RESP_OKAY;
      ctrl_r        <= pcs_core_pkg::CTRL_RST;
      cfg_r         <= pcs_core_pkg::CFG_RST;
      rejected_r    <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= pcs_core_pkg::RESP_OKAY;
        case (awaddr_r)
          pcs_core_pkg::CTRL_OFFS: begin
            ctrl_r <= ctrl_nxt;
            // A request that the width check or the simplified interface forbids is flagged.
            rejected_r <= ctrl_nxt[pcs_core_pkg::CTRL_DRT_BIT]
                       && (!drt_ok || ctrl_nxt[pcs_core_pkg::CTRL_SIMP_BIT]);
          end
          pcs_core_pkg::CFG_OFFS: begin
            cfg_r <= wdata_r;
          end
          default: begin
            s_axi_bresp <= pcs_core_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pcs_core_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pcs_core_pkg::RESP_OKAY;
        case (s_axi_araddr[7:0])
          pcs_core_pkg::CTRL_OFFS:    s_axi_rdata <= ctrl_r;
          pcs_core_pkg::BITREV_OFFS:  s_axi_rdata <= 32'(bitf_r);
          pcs_core_pkg::BYTEREV_OFFS: s_axi_rdata <= 32'(bytef_r);
          pcs_core_pkg::CFG_OFFS:     s_axi_rdata <= cfg_r;
          pcs_core_pkg::STATUS_OFFS: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rdata[pcs_core_pkg::ST_DRT_BIT] <= drt_on;
            s_axi_rdata[pcs_core_pkg::ST_REJ_BIT] <= rejected_r;
            s_axi_rdata[pcs_core_pkg::ST_LOW_BIT] <= low_seen_r;
            s_axi_rdata[pcs_core_pkg::ST_UP_BIT]  <= up_seen_r;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pcs_core_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Rate phases
  // ----------------------------------------
  // The fabric runs at the doubled rate; a phase toggle marks full-rate beats.
  // In the narrow case the phase follows the fabric-supplied doubled clock instead.
  logic phase_r;
  logic use_ext;
  logic ext_edge;

  assign use_ext  = ctrl_r[pcs_core_pkg::CTRL_X1_BIT]
                 && (cfg_r[pcs_core_pkg::CFG_PCSW_LSB +: 8] == 8'(pcs_core_pkg::NARROW_PCS_W));
  assign ext_edge = dclk_s2_r && !dclk_s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r              <= 1'b0;
      tx_full_rate_clk_out <= 1'b0;
      rx_full_rate_clk_out <= 1'b0;
    end else if (clk_en) begin
      if (!use_ext || ext_edge) begin
        phase_r <= !phase_r;
      end
      tx_full_rate_clk_out <= drt_on && phase_r;
      rx_full_rate_clk_out <= drt_on && phase_r;
    end
  end

  // ----------------------------------------
  // Transmit: halves to full word
  // ----------------------------------------
  logic [CH*HW-1:0] tx_low_r;
  logic [CH*FW-1:0] tx_asm;
  logic [CH*FW-1:0] tx_fix;

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_tx
      // Upper half pairs with the latched lower half by the fabric's marking bit.
      assign tx_asm[g*FW +: FW] = drt_on ?
        {tx_half_data[g*HW +: HW], tx_low_r[g*HW +: HW]} :
        {{(FW-HW){1'b0}}, tx_half_data[g*HW +: HW]};
      assign tx_fix[g*FW +: FW] =
        ctrl_r[pcs_core_pkg::CTRL_TXBIT_BIT] ? mirror_full(tx_asm[g*FW +: FW]) :
        ctrl_r[pcs_core_pkg::CTRL_TXBYT_BIT] ? swap_full(tx_asm[g*FW +: FW]) :
        tx_asm[g*FW +: FW];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_low_r          <= '0;
      tx_pcs_word       <= '0;
      tx_pcs_word_valid <= 1'b0;
      low_seen_r        <= 1'b0;
      up_seen_r         <= 1'b0;
    end else if (clk_en) begin
      tx_pcs_word_valid <= 1'b0;
      for (int c = 0; c < CH; c++) begin
        if (!tx_half_mark[c]) begin
          tx_low_r[c*HW +: HW] <= tx_half_data[c*HW +: HW];
        end
      end
      if (drt_on) begin
        low_seen_r <= low_seen_r || !tx_half_mark[0];
        up_seen_r  <= up_seen_r || tx_half_mark[0];
        if (tx_half_mark[0]) begin
          tx_pcs_word       <= tx_fix;
          tx_pcs_word_valid <= 1'b1;
        end
      end else begin
        tx_pcs_word       <= tx_fix;
        tx_pcs_word_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Receive: full word to halves
  // ----------------------------------------
  // The aligner mode never gates the reversal; only the per-channel enables do.
  logic [CH*FW-1:0] rx_hold_r;
  logic             rx_upper_r;
  logic             rx_pend_r;
  logic             rx_inv;
  logic [CH*FW-1:0] rx_full;
  logic [CH*HW-1:0] rx_fix;

  assign rx_inv = ctrl_r[pcs_core_pkg::CTRL_INV_BIT];

  generate
    for (g = 0; g < CH; g++) begin : g_rx
      assign rx_full[g*FW +: FW] =
        bitf_r[g]  ? mirror_full(rx_hold_r[g*FW +: FW]) :
        bytef_r[g] ? swap_full(rx_hold_r[g*FW +: FW]) :
        rx_hold_r[g*FW +: FW];
      assign rx_fix[g*HW +: HW] = rx_upper_r ?
        rx_full[g*FW + HW +: HW] : rx_full[g*FW +: HW];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_r     <= '0;
      rx_upper_r    <= 1'b0;
      rx_pend_r     <= 1'b0;
      rx_half_data  <= '0;
      rx_half_mark  <= '0;
      rx_half_valid <= 1'b0;
    end else if (clk_en) begin
      rx_half_valid <= 1'b0;
      if (rx_pend_r) begin
        rx_half_data  <= rx_fix;
        rx_half_mark  <= {CH{rx_upper_r ^ rx_inv}};
        rx_half_valid <= 1'b1;
        rx_upper_r    <= 1'b1;
        rx_pend_r     <= drt_on && !rx_upper_r;
      end
      if (rx_pcs_word_valid) begin
        rx_hold_r  <= rx_pcs_word;
        rx_upper_r <= 1'b0;
        rx_pend_r  <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- include/pcs_core_pkg.sv ----
// Package of constants for the PCS-to-fabric datapath options block.
// Assumes a single 100 MHz aclk domain and AXI4-Lite register access.
package pcs_core_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned CHANNELS       = 4;
  localparam int unsigned FULL_W         = 80;
  localparam int unsigned HALF_W         = 40;
  localparam int unsigned SYM_W          = 10;
  localparam int unsigned MIN_DRT_W      = 10;
  localparam int unsigned NARROW_PCS_W   = 20;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFS       = 8'h00;
  localparam logic [7:0] BITREV_OFFS     = 8'h04;
  localparam logic [7:0] BYTEREV_OFFS    = 8'h08;
  localparam logic [7:0] CFG_OFFS        = 8'h0C;
  localparam logic [7:0] STATUS_OFFS     = 8'h10;

  // ----------------------------------------
  // Control register field positions
  // ----------------------------------------
  localparam int unsigned CTRL_DRT_BIT   = 0;
  localparam int unsigned CTRL_SIMP_BIT  = 1;
  localparam int unsigned CTRL_TXBIT_BIT = 2;
  localparam int unsigned CTRL_TXBYT_BIT = 3;
  localparam int unsigned CTRL_INV_BIT   = 4;
  localparam int unsigned CTRL_X1_BIT    = 5;

  // ----------------------------------------
  // Config register field positions
  // ----------------------------------------
  localparam int unsigned CFG_PCSW_LSB   = 0;
  localparam int unsigned CFG_COREW_LSB  = 8;

  // ----------------------------------------
  // Status register field positions
  // ----------------------------------------
  localparam int unsigned ST_DRT_BIT     = 0;
  localparam int unsigned ST_REJ_BIT     = 1;
  localparam int unsigned ST_LOW_BIT     = 2;
  localparam int unsigned ST_UP_BIT      = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] CFG_RST        = 32'h0000_2828;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

endpackage

// ---- test/pcs_core_properties.sv ----
// Checker for the datapath options block, bound to its top module.
// Assumes clk_en is held high and the full-rate clock outputs flag double rate.
`timescale 1ns/1ps
`default_nettype none
module pcs_core_properties (
  input wire logic                               aclk,
  input wire logic                               aresetn,
  input wire logic                               s_axi_awvalid,
  input wire logic                               s_axi_wvalid,
  input wire logic [1:0]                         s_axi_bresp,
  input wire logic                               s_axi_bvalid,
  input wire logic                               s_axi_bready,
  input wire logic                               s_axi_arvalid,
  input wire logic                               s_axi_rvalid,
  input wire logic [pcs_core_pkg::CHANNELS-1:0]  tx_half_mark,
  input wire logic                               tx_pcs_word_valid,
  input wire logic                               rx_pcs_word_valid,
  input wire logic [pcs_core_pkg::CHANNELS-1:0]  rx_half_mark,
  input wire logic                               rx_half_valid,
  input wire logic                               tx_full_rate_clk_out,
  input wire logic                               rx_full_rate_clk_out
);
  // ----------------------------------------
  // Double rate seen from the ports
  // ----------------------------------------
  // The full-rate clock is high every other cycle, so two samples are needed.
  logic drt_r;
  logic drt_w;
  always_ff @(posedge aclk) begin
    if (!aresetn) drt_r <= 1'b0;
    else drt_r <= tx_full_rate_clk_out;
  end
  assign drt_w = drt_r | tx_full_rate_clk_out;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rx_lower_next_a: assert property (rx_pcs_word_valid |-> ##2 rx_half_valid)
    else $error("lower half missing");
  rx_upper_next_a: assert property (
    rx_pcs_word_valid && drt_w |-> ##2 rx_half_valid ##1 rx_half_valid)
    else $error("upper half missing");
  rx_single_half_a: assert property (
    rx_pcs_word_valid && !drt_w ##1 !rx_pcs_word_valid |=> rx_half_valid ##1 !rx_half_valid)
    else $error("extra half without double rate");
  mark_toggle_a: assert property (
    rx_pcs_word_valid && drt_w |-> ##3 (rx_half_mark == ~$past(rx_half_mark)))
    else $error("half marks not opposite");
  tx_after_upper_a: assert property (tx_pcs_word_valid && tx_full_rate_clk_out
    |-> $past(tx_half_mark[0]) || $past(tx_half_mark[0], 2))
    else $error("word sent without upper half");
  clk_toggle_a: assert property (tx_full_rate_clk_out |=> !tx_full_rate_clk_out)
    else $error("full rate clock not toggling");
  clk_match_a: assert property (tx_full_rate_clk_out == rx_full_rate_clk_out)
    else $error("full rate clocks differ");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
    else $error("read data late");
  cover property (rx_half_valid ##1 rx_half_valid);
  cover property (tx_pcs_word_valid && tx_full_rate_clk_out);
  cover property (s_axi_bvalid && s_axi_bresp == pcs_core_pkg::RESP_SLVERR);
endmodule
bind pcs_core_reversal_double_rate pcs_core_properties pcs_core_properties_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_rvalid, .tx_half_mark, .tx_pcs_word_valid,
  .rx_pcs_word_valid, .rx_half_mark, .rx_half_valid, .tx_full_rate_clk_out,
  .rx_full_rate_clk_out);
`default_nettype wire

// ---- test/fabric_tx_model.sv ----
// Fabric side that splits full transmit words into marked half words.
// Assumes the caller pulses send for one cycle with word held valid.
`timescale 1ns/1ps
`default_nettype none
module fabric_tx_model (
  input  wire logic                                                  aclk,
  input  wire logic                                                  send,
  input  wire logic [pcs_core_pkg::CHANNELS*pcs_core_pkg::FULL_W-1:0] word,
  output logic      [pcs_core_pkg::CHANNELS*pcs_core_pkg::HALF_W-1:0] half,
  output logic      [pcs_core_pkg::CHANNELS-1:0]                      mark
);
  // ----------------------------------------
  // Half word sequencing
  // ----------------------------------------
  logic [pcs_core_pkg::CHANNELS*pcs_core_pkg::FULL_W-1:0] word_r = '0;
  logic                                                   up_r = 1'b0;
  initial half = '0;
  initial mark = '0;
  always @(posedge aclk) begin
    up_r <= send;
    if (send) word_r <= word;
    for (int c = 0; c < pcs_core_pkg::CHANNELS; c++) begin
      if (send) half[c*40+:40] <= word[c*80+:40];
      else if (up_r) half[c*40+:40] <= word_r[c*80+40+:40];
      else half[c*40+:40] <= ~half[c*40+:40];
    end
    // Idle data keeps changing so stale halves are never mistaken for new ones.
    mark <= up_r ? '1 : '0;
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the datapath options block.
// Assumes a single 100 MHz clock; clk_en is held high throughout.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------
  localparam int CH = pcs_core_pkg::CHANNELS;
  localparam int FW = CH*pcs_core_pkg::FULL_W;
  localparam int HW = CH*pcs_core_pkg::HALF_W;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_pcs_word_valid, rx_half_valid, send = 0, chk_tx = 0;
  logic rx_pcs_word_valid = 0, tx_full_rate_clk_out, rx_full_rate_clk_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [FW-1:0] rx_pcs_word = '0, tx_word = '0, tx_pcs_word;
  logic [HW-1:0] tx_half_data, rx_half_data;
  logic [CH-1:0] tx_half_mark, rx_half_mark, rx_bit_flip_en = '0, rx_byte_swap_en = '0;
  logic [31:0] seed = 32'h0000_2FE6;
  int n_mismatch = 0, comparisons = 0;
  logic [FW-1:0] tq[$];
  logic [HW+CH-1:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] dq[$];
  initial forever #5 aclk = ~aclk;
  pcs_core_reversal_double_rate pcs_core_reversal_double_rate_i (
    .aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_fabric_doubled_clk_in(1'b0), .tx_half_data, .tx_half_mark, .tx_pcs_word,
    .tx_pcs_word_valid, .rx_pcs_word, .rx_pcs_word_valid, .rx_bit_flip_en,
    .rx_byte_swap_en, .rx_half_data, .rx_half_mark, .rx_half_valid,
    .tx_full_rate_clk_out, .rx_full_rate_clk_out);
  fabric_tx_model fabric_tx_model_i (
    .aclk, .send, .word(tx_word), .half(tx_half_data), .mark(tx_half_mark));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [FW-1:0] rndw();
    for (int i = 0; i < FW/32; i++) rndw[i*32+:32] = rnd();
  endfunction
  function automatic logic [79:0] xf(input logic [79:0] w, input logic br, input logic sy);
    xf = w;
    for (int i = 0; i < 80; i++) if (br) xf[i] = w[79-i];
    for (int k = 0; k < 8; k++) if (sy && !br) xf[k*10+:10] = w[70-k*10+:10];
  endfunction
  task automatic check(input logic [FW-1:0] seen, input logic [FW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    n_mismatch += tq.size() + rq.size() + bq.size() + dq.size();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
      if (s_axi_wvalid && s_axi_wready) wd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    dq.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rx_send(input logic drt, input logic inv);
    logic [FW-1:0] w, x;
    logic [HW-1:0] lo, hi;
    w = rndw();
    for (int c = 0; c < CH; c++) begin
      x[c*80+:80] = xf(w[c*80+:80], rx_bit_flip_en[c], rx_byte_swap_en[c]);
      lo[c*40+:40] = x[c*80+:40];
      hi[c*40+:40] = x[c*80+40+:40];
    end
    rq.push_back({{CH{inv}}, lo});
    if (drt) rq.push_back({{CH{~inv}}, hi});
    repeat (3) @(posedge aclk);
    rx_pcs_word <= w;
    rx_pcs_word_valid <= 1'b1;
    @(posedge aclk);
    rx_pcs_word <= ~w;
    rx_pcs_word_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic tx_send(input logic br, input logic sy);
    logic [FW-1:0] w, x;
    w = rndw();
    for (int c = 0; c < CH; c++) x[c*80+:80] = xf(w[c*80+:80], br, sy);
    tq.push_back(x);
    @(posedge aclk);
    tx_word <= w;
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (aresetn) begin
      if (s_axi_bvalid && s_axi_bready) check(FW'(s_axi_bresp), FW'(bq.pop_front()));
      if (s_axi_rvalid && s_axi_rready)
        check(FW'({s_axi_rresp, s_axi_rdata}), FW'(dq.pop_front()));
      if (tx_pcs_word_valid && chk_tx) check(tx_pcs_word, tq.pop_front());
      if (rx_half_valid)
        check(FW'({rx_half_mark, rx_half_data}), FW'(rq.pop_front()));
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    static logic [31:0] cfgs[4] = '{32'h280A, 32'h0A28, 32'h0B0B, 32'h2828};
    static logic [31:0] ctls[4] = '{32'h1, 32'h1, 32'h1, 32'h3};
    static logic [3:0] drts = 4'h4;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(pcs_core_pkg::CTRL_OFFS, pcs_core_pkg::CTRL_RST, pcs_core_pkg::RESP_OKAY);
    axr(pcs_core_pkg::CFG_OFFS, pcs_core_pkg::CFG_RST, pcs_core_pkg::RESP_OKAY);
    axr(8'h14, 32'h0, pcs_core_pkg::RESP_SLVERR);
    axw(8'h14, 32'h1, pcs_core_pkg::RESP_SLVERR);
    rx_send(1'b0, 1'b0);
    axw(pcs_core_pkg::CTRL_OFFS, 32'h1, pcs_core_pkg::RESP_OKAY);
    rx_send(1'b1, 1'b0);
    axw(pcs_core_pkg::CTRL_OFFS, 32'h11, pcs_core_pkg::RESP_OKAY);
    rx_send(1'b1, 1'b1);
    rx_bit_flip_en <= 4'h5;
    rx_byte_swap_en <= 4'h6;
    repeat (4) @(posedge aclk);
    axr(pcs_core_pkg::BITREV_OFFS, 32'h5, pcs_core_pkg::RESP_OKAY);
    axr(pcs_core_pkg::BYTEREV_OFFS, 32'h6, pcs_core_pkg::RESP_OKAY);
    axw(pcs_core_pkg::CTRL_OFFS, 32'h1, pcs_core_pkg::RESP_OKAY);
    rx_send(1'b1, 1'b0);
    rx_bit_flip_en <= '0;
    rx_byte_swap_en <= '0;
    chk_tx = 1'b1;
    for (int i = 0; i < 4; i++) begin
      axw(pcs_core_pkg::CTRL_OFFS, {28'h0, i[1:0], 2'b01}, pcs_core_pkg::RESP_OKAY);
      tx_send(i[0], i[1]);
    end
    chk_tx = 1'b0;
    for (int i = 0; i < 4; i++) begin
      axw(pcs_core_pkg::CFG_OFFS, cfgs[i], pcs_core_pkg::RESP_OKAY);
      axr(pcs_core_pkg::CFG_OFFS, cfgs[i], pcs_core_pkg::RESP_OKAY);
      axw(pcs_core_pkg::CTRL_OFFS, ctls[i], pcs_core_pkg::RESP_OKAY);
      axr(pcs_core_pkg::STATUS_OFFS, {28'h0, 2'h3, ~drts[i], drts[i]},
          pcs_core_pkg::RESP_OKAY);
      repeat (4) @(posedge aclk);
      rx_send(drts[i], 1'b0);
    end
    print_verdict();
  end
  initial begin
    #60000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
